/* File: inc/serial_adapter_map.svh */
`ifndef SERIAL_ADAPTER_MAP_SVH
`define SERIAL_ADAPTER_MAP_SVH

// control word fields
`define SCW_DIV_LSB      0
`define SCW_DIV_MSB      1
`define SCW_FMT_LSB      2
`define SCW_FMT_MSB      4
`define SCW_TXC_LSB      5
`define SCW_TXC_MSB      6
`define SCW_RXIE_BIT     7
`define SCW_RESET_VAL    8'h03

// clock division codes
`define DIV_CODE_1       2'h0
`define DIV_CODE_16      2'h1
`define DIV_CODE_64      2'h2
`define DIV_CODE_RST     2'h3
`define DIV_RATIO_16     7'h10
`define DIV_RATIO_64     7'h40

// transmit control codes
`define TXC_IE_ON        2'h1
`define TXC_BREAK        2'h3

// parallel adapter control bit that selects the port register
`define PIA_SEL_BIT      2
`define PIA_CTRL_RESET   8'h00

`endif

/* File: inc/serial_adapter_pkg.sv */
package serial_adapter_pkg;

   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_START = 5'h02,
      TX_DATA  = 5'h04,
      TX_PAR   = 5'h08,
      TX_STOP  = 5'h10
   } tx_state_e;

endpackage

/* File: src/serial_adapter_control.sv */
`include "serial_adapter_map.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_adapter_control #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              clk_en_i,
   // control word write
   input  wire logic              ctrl_wr_i,
   input  wire logic [7:0]        ctrl_data_i,
   // baud rate clock pulses from the rate generator
   input  wire logic              baud_tick_i,
   // transmit stream
   input  wire logic              tx_valid_i,
   output logic                   tx_ready_o,
   input  wire logic [DATA_W-1:0] tx_data_i,
   // serial line
   output logic                   txd_o,
   // interrupt request levels
   output logic                   tx_irq_o,
   output logic                   rx_irq_o,
   input  wire logic              rx_full_i,
   // parallel adapter select
   input  wire logic              pia_ctrl_wr_i,
   input  wire logic [7:0]        pia_ctrl_data_i,
   input  wire logic              pia_data_acc_i,
   output logic                   pia_port_sel_o,
   output logic                   pia_ddr_sel_o,
   // decoded format
   output logic                   in_reset_o,
   output logic                   eight_bits_o,
   output logic                   parity_en_o,
   output logic                   parity_odd_o,
   output logic                   two_stop_o
);

   // ----------------------------------------
   // control word
   // ----------------------------------------
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic       in_reset;
   logic       next_in_reset;
   logic [7:0] pia_ctrl;
   logic [7:0] next_pia_ctrl;

   always_comb begin
      next_ctrl     = ctrl;
      next_in_reset = in_reset;
      next_pia_ctrl = pia_ctrl;
      if (ctrl_wr_i) begin
         next_ctrl = ctrl_data_i;
         // reset code enters reset, any other division leaves it
         next_in_reset = (ctrl_data_i[`SCW_DIV_MSB:`SCW_DIV_LSB] == `DIV_CODE_RST);
      end
      if (pia_ctrl_wr_i) begin
         next_pia_ctrl = pia_ctrl_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ctrl     <= `SCW_RESET_VAL;
         in_reset <= 1'b1;
         pia_ctrl <= `PIA_CTRL_RESET;
      end else if (clk_en_i) begin
         ctrl     <= next_ctrl;
         in_reset <= next_in_reset;
         pia_ctrl <= next_pia_ctrl;
      end
   end

   // ----------------------------------------
   // format decode
   // ----------------------------------------
   logic [2:0] fmt;
   logic [1:0] txc;
   logic [6:0] ratio;

   assign fmt = ctrl[`SCW_FMT_MSB:`SCW_FMT_LSB];
   assign txc = ctrl[`SCW_TXC_MSB:`SCW_TXC_LSB];

   always_comb begin
      eight_bits_o = fmt[2];
      parity_en_o  = !fmt[2] || fmt[1];
      parity_odd_o = fmt[0] && parity_en_o;
      two_stop_o   = fmt[2] ? (fmt[1:0] == 2'b00) : !fmt[1];
      case (ctrl[`SCW_DIV_MSB:`SCW_DIV_LSB])
         `DIV_CODE_16: ratio = `DIV_RATIO_16;
         `DIV_CODE_64: ratio = `DIV_RATIO_64;
         default:      ratio = 7'h01; // divide by one, also taken for the reset code
      endcase
   end

   assign in_reset_o = in_reset;

   // ----------------------------------------
   // two-entry transmit buffer
   // ----------------------------------------
   logic [DATA_W-1:0] buf_mem [2];
   logic [DATA_W-1:0] next_buf0;
   logic [DATA_W-1:0] next_buf1;
   logic              wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [1:0]        count, next_count;
   logic              buf_pop;
   logic              push;

   assign tx_ready_o = !in_reset && (count != 2'h2);
   assign push       = tx_valid_i && tx_ready_o;

   always_comb begin
      next_buf0   = buf_mem[0];
      next_buf1   = buf_mem[1];
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         if (wr_ptr) next_buf1 = tx_data_i;
         else        next_buf0 = tx_data_i;
         next_wr_ptr = !wr_ptr;
      end
      if (buf_pop) begin
         next_rd_ptr = !rd_ptr;
      end
      next_count = count + {1'b0, push} - {1'b0, buf_pop};
      if (in_reset) begin
         next_wr_ptr = 1'b0;
         next_rd_ptr = 1'b0;
         next_count  = 2'h0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
         wr_ptr     <= 1'b0;
         rd_ptr     <= 1'b0;
         count      <= 2'h0;
      end else if (clk_en_i) begin
         buf_mem[0] <= next_buf0;
         buf_mem[1] <= next_buf1;
         wr_ptr     <= next_wr_ptr;
         rd_ptr     <= next_rd_ptr;
         count      <= next_count;
      end
   end

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   serial_adapter_pkg::tx_state_e state, next_state;
   logic [DATA_W-1:0] shreg, next_shreg;
   logic [3:0]        bit_cnt, next_bit_cnt;
   logic [6:0]        div_cnt, next_div_cnt;
   logic              par, next_par;
   logic              txd, next_txd;
   logic              bit_end;

   assign bit_end = baud_tick_i && (div_cnt == ratio - 7'h01);

   always_comb begin
      next_state   = state;
      next_shreg   = shreg;
      next_bit_cnt = bit_cnt;
      next_par     = par;
      next_txd     = txd;
      buf_pop      = 1'b0;
      next_div_cnt = div_cnt;
      if (baud_tick_i) begin
         next_div_cnt = bit_end ? 7'h00 : div_cnt + 7'h01;
      end
      case (state)
         serial_adapter_pkg::TX_IDLE: begin
            next_txd     = 1'b1;
            next_div_cnt = 7'h00;
            // one mark cycle after a break, so the far end sees a start edge
            if (count != 2'h0 && txc != `TXC_BREAK && txd) begin
               next_shreg = buf_mem[rd_ptr];
               buf_pop    = 1'b1;
               next_par   = parity_odd_o;
               next_state = serial_adapter_pkg::TX_START;
               next_txd   = 1'b0;
            end
         end
         serial_adapter_pkg::TX_START: begin
            if (bit_end) begin
               next_state   = serial_adapter_pkg::TX_DATA;
               next_bit_cnt = eight_bits_o ? 4'h8 : 4'h7;
               next_txd     = shreg[0];
               next_par     = par ^ shreg[0];
               next_shreg   = shreg >> 1;
            end
         end
         serial_adapter_pkg::TX_DATA: begin
            if (bit_end) begin
               next_bit_cnt = bit_cnt - 4'h1;
               if (bit_cnt == 4'h1) begin
                  next_state   = parity_en_o ? serial_adapter_pkg::TX_PAR : serial_adapter_pkg::TX_STOP;
                  next_txd     = parity_en_o ? par : 1'b1;
                  next_bit_cnt = two_stop_o ? 4'h2 : 4'h1;
               end else begin
                  next_txd   = shreg[0];
                  next_par   = par ^ shreg[0];
                  next_shreg = shreg >> 1;
               end
            end
         end
         serial_adapter_pkg::TX_PAR: begin
            if (bit_end) begin
               next_state = serial_adapter_pkg::TX_STOP;
               next_txd   = 1'b1;
            end
         end
         serial_adapter_pkg::TX_STOP: begin
            if (bit_end) begin
               next_bit_cnt = bit_cnt - 4'h1;
               if (bit_cnt == 4'h1) next_state = serial_adapter_pkg::TX_IDLE;
            end
         end
         default: next_state = serial_adapter_pkg::TX_IDLE;
      endcase
      // break forces spacing; the frame in flight is abandoned
      if (txc == `TXC_BREAK) begin
         next_txd   = 1'b0;
         next_state = serial_adapter_pkg::TX_IDLE;
      end
      if (in_reset) begin
         next_state = serial_adapter_pkg::TX_IDLE;
         next_txd   = 1'b1;
         buf_pop    = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state   <= serial_adapter_pkg::TX_IDLE;
         shreg   <= '0;
         bit_cnt <= 4'h0;
         div_cnt <= 7'h00;
         par     <= 1'b0;
         txd     <= 1'b1;
      end else if (clk_en_i) begin
         state   <= next_state;
         shreg   <= next_shreg;
         bit_cnt <= next_bit_cnt;
         div_cnt <= next_div_cnt;
         par     <= next_par;
         txd     <= next_txd;
      end
   end

   assign txd_o = txd;

   // ----------------------------------------
   // interrupts and parallel select
   // ----------------------------------------
   always_comb begin
      tx_irq_o = !in_reset && (txc == `TXC_IE_ON) && (count == 2'h0);
      rx_irq_o = !in_reset && ctrl[`SCW_RXIE_BIT] && rx_full_i;
      pia_port_sel_o = pia_data_acc_i && pia_ctrl[`PIA_SEL_BIT];
      pia_ddr_sel_o  = pia_data_acc_i && !pia_ctrl[`PIA_SEL_BIT];
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_break_spacing: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (clk_en_i && !in_reset && ctrl[6:5] == 2'b11) |=> !txd_o)
      else $error("break not spacing");
   a_tx_irq_code: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      tx_irq_o |-> ctrl[6:5] == 2'b01) else $error("tx irq with wrong code");
   a_rx_irq_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (rx_full_i && !in_reset) |-> rx_irq_o == ctrl[7]) else $error("rx irq gating wrong");
   a_reset_enter: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (clk_en_i && ctrl_wr_i && ctrl_data_i[1:0] == 2'b11) |=> in_reset_o ##1 (txd_o || !$past(clk_en_i)))
      else $error("master reset not taken");
   a_reset_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (in_reset_o && !ctrl_wr_i) |=> in_reset_o && !tx_ready_o) else $error("reset left early");
   a_fmt_seven: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ctrl[4] == 1'b0) |-> (!eight_bits_o && parity_en_o && parity_odd_o == ctrl[2]
      && two_stop_o == !ctrl[3])) else $error("seven bit format wrong");
   a_fmt_eight_np: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ctrl[4:3] == 2'b10) |-> (eight_bits_o && !parity_en_o && two_stop_o == !ctrl[2]))
      else $error("eight bit no parity format wrong");
   a_fmt_eight_p: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ctrl[4:3] == 2'b11) |-> (eight_bits_o && parity_en_o && !two_stop_o && parity_odd_o == ctrl[2]))
      else $error("eight bit parity format wrong");
   a_pia_port: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (clk_en_i && pia_ctrl_wr_i && pia_ctrl_data_i[2]) ##1 (pia_data_acc_i && !pia_ctrl_wr_i)
      |-> pia_port_sel_o && !pia_ddr_sel_o) else $error("port register not selected");
   a_pia_ddr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (pia_data_acc_i && !pia_ctrl[2]) |-> pia_ddr_sel_o && !pia_port_sel_o)
      else $error("direction register not selected");

   c_frame_start: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state == serial_adapter_pkg::TX_START);
   c_buffer_full: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      count == 2'h2);
   c_parity_bit: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state == serial_adapter_pkg::TX_PAR);
   c_break_sent: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !in_reset && txc == `TXC_BREAK && !txd_o);

endmodule

`default_nettype wire

/* File: tb/serial_terminal_model.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_terminal_model (
   // clock and line
   input  wire logic       clk_i,
   input  wire logic       txd_i,
   // format the terminal is set up for
   input  wire logic [6:0] bit_cycles_i,
   input  wire logic       eight_i,
   input  wire logic       par_en_i,
   input  wire logic       par_odd_i,
   input  wire logic       two_stop_i,
   // last received frame
   output logic [7:0]      word_o,
   output logic            par_err_o,
   output logic            stop_err_o,
   output logic [7:0]      frames_o
);
   // ------------------------------------------
   // frame receiver
   // ------------------------------------------
   logic prev;

   initial begin
      word_o = 8'h00;
      par_err_o = 1'b0;
      stop_err_o = 1'b0;
      frames_o = 8'h00;
      prev = 1'b1;
      forever begin
         @(posedge clk_i);
         // hunts only on a mark-to-space edge, so a long break costs one bad frame
         if (prev === 1'b1 && txd_i === 1'b0) begin
            repeat (bit_cycles_i / 2) @(posedge clk_i);
            word_o = 8'h00;
            for (int i = 0; i < (eight_i ? 8 : 7); i++) begin
               repeat (bit_cycles_i) @(posedge clk_i);
               word_o[i] = txd_i;
            end
            par_err_o = 1'b0;
            if (par_en_i) begin
               repeat (bit_cycles_i) @(posedge clk_i);
               par_err_o = txd_i !== (^word_o ^ par_odd_i);
            end
            repeat (bit_cycles_i) @(posedge clk_i);
            stop_err_o = txd_i !== 1'b1;
            if (two_stop_i) begin
               repeat (bit_cycles_i) @(posedge clk_i);
               stop_err_o = stop_err_o | (txd_i !== 1'b1);
            end
            frames_o++;
         end
         prev = txd_i;
      end
   end
endmodule

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end

module tb;
   logic       sys_clk_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic       clk_en_i = 1'b1;
   logic       ctrl_wr_i = 1'b0;
   logic [7:0] ctrl_data_i = 8'h00;
   // every cycle is a tick: a slower tick would make the start bit length jitter by a cycle
   logic       baud_tick_i = 1'b1;
   logic       tx_valid_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic       rx_full_i = 1'b0;
   logic       pia_ctrl_wr_i = 1'b0;
   logic [7:0] pia_ctrl_data_i = 8'h00;
   logic       pia_data_acc_i = 1'b0;
   logic       tx_ready_o, txd_o, tx_irq_o, rx_irq_o, pia_port_sel_o, pia_ddr_sel_o;
   logic       in_reset_o, eight_bits_o, parity_en_o, parity_odd_o, two_stop_o;
   logic [6:0] bit_cycles = 7'h01;
   logic       m_eight = 1'b1, m_par = 1'b0, m_odd = 1'b0, m_two = 1'b0;
   logic [7:0] rx_word, frames;
   logic       rx_perr, rx_serr;
   int         miscompares = 0;
   int         n_tests = 0;
   int         cycles = 0;

   serial_adapter_control #(.DATA_W(8)) serial_adapter_control_inst (.sys_clk_i, .sys_rst_i, .clk_en_i, .ctrl_wr_i,
      .ctrl_data_i, .baud_tick_i, .tx_valid_i, .tx_ready_o, .tx_data_i, .txd_o, .tx_irq_o, .rx_irq_o, .rx_full_i,
      .pia_ctrl_wr_i, .pia_ctrl_data_i, .pia_data_acc_i, .pia_port_sel_o, .pia_ddr_sel_o, .in_reset_o,
      .eight_bits_o, .parity_en_o, .parity_odd_o, .two_stop_o);

   serial_terminal_model serial_terminal_model_inst (.clk_i(sys_clk_i), .txd_i(txd_o), .bit_cycles_i(bit_cycles),
      .eight_i(m_eight), .par_en_i(m_par), .par_odd_i(m_odd), .two_stop_i(m_two), .word_o(rx_word),
      .par_err_o(rx_perr), .stop_err_o(rx_serr), .frames_o(frames));

   always #2 sys_clk_i = ~sys_clk_i;

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   // ------------------------------------------
   // stimulus tasks
   // ------------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic wr_ctrl(input logic [7:0] v);
      ctrl_data_i = v;
      ctrl_wr_i = 1'b1;
      cyc(1);
      ctrl_wr_i = 1'b0;
      cyc(1);
   endtask

   // leaves valid high so back to back pushes never toggle it within one step
   task automatic push(input logic [7:0] d);
      int k = 0;
      tx_data_i = d;
      tx_valid_i = 1'b1;
      while (tx_ready_o !== 1'b1 && k < 500) begin
         cyc(1);
         k++;
      end
      cyc(1);
   endtask

   task automatic wait_frame(input logic [7:0] n);
      int k = 0;
      while (frames !== n && k < 3000) begin
         cyc(1);
         k++;
      end
   endtask

   task automatic set_model(input logic [7:0] c);
      bit_cycles = (c[1:0] == 2'h1) ? 7'h10 : (c[1:0] == 2'h2) ? 7'h40 : 7'h01;
      m_eight = c[4];
      m_par = !(c[4] && !c[3]);
      m_odd = c[2];
      m_two = c[4] ? (c[4:2] == 3'h4) : !c[3];
   endtask

   task automatic t_frame(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] f0;
      int n = 0;
      int k = 0;
      f0 = frames;
      set_model(c);
      wr_ctrl(c);
      `CHK({in_reset_o, eight_bits_o, parity_en_o, two_stop_o}, {1'b0, m_eight, m_par, m_two})
      if (m_par) `CHK(parity_odd_o, m_odd)
      push(d);
      tx_valid_i = 1'b0;
      while (txd_o !== 1'b0 && k < 100) begin
         cyc(1);
         k++;
      end
      while (txd_o === 1'b0 && n < 200) begin
         cyc(1);
         n++;
      end
      `CHK(n, int'(bit_cycles))
      wait_frame(f0 + 8'h01);
      `CHK(rx_word, m_eight ? d : {1'b0, d[6:0]})
      `CHK({rx_perr, rx_serr}, 2'b00)
      $display("frame test done, control %h", c);
   endtask

   task automatic t_pia(input logic [7:0] v, input logic [1:0] e);
      pia_ctrl_data_i = v;
      pia_ctrl_wr_i = 1'b1;
      cyc(1);
      pia_ctrl_wr_i = 1'b0;
      cyc(1);
      `CHK({pia_port_sel_o, pia_ddr_sel_o}, e)
      $display("parallel select test done, control %h", v);
   endtask

   task automatic t_irq();
      for (int c = 0; c < 4; c++) begin
         wr_ctrl({1'b0, c[1:0], 5'h15});
         `CHK(tx_irq_o, c == 1)
         `CHK(txd_o, c != 3)
      end
      rx_full_i = 1'b1;
      wr_ctrl(8'h95);
      `CHK(rx_irq_o, 1'b1)
      wr_ctrl(8'h15);
      `CHK(rx_irq_o, 1'b0)
      wr_ctrl(8'hb7);
      `CHK({in_reset_o, tx_ready_o, rx_irq_o, tx_irq_o, txd_o}, 5'b10001)
      clk_en_i = 1'b0;
      wr_ctrl(8'h95);
      clk_en_i = 1'b1;
      cyc(3);
      `CHK(in_reset_o, 1'b1)
      wr_ctrl(8'h95);
      `CHK({in_reset_o, rx_irq_o}, 2'b01)
      rx_full_i = 1'b0;
      $display("interrupt and master reset test done");
   endtask

   task automatic t_break();
      logic [7:0] f0;
      set_model(8'h14);
      wr_ctrl(8'h74);
      push(8'h5a);
      push(8'ha5);
      `CHK(tx_ready_o, 1'b0)
      tx_valid_i = 1'b0;
      `CHK({txd_o, tx_irq_o}, 2'b00)
      cyc(30);
      `CHK(txd_o, 1'b0)
      f0 = frames;
      wr_ctrl(8'h14);
      wait_frame(f0 + 8'h01);
      `CHK(rx_word, 8'h5a)
      wait_frame(f0 + 8'h02);
      `CHK({rx_word, rx_serr, tx_ready_o}, {8'ha5, 1'b0, 1'b1})
      $display("break and buffer test done");
   endtask

   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      cyc(12);
      sys_rst_i = 1'b0;
      pia_data_acc_i = 1'b1;
      cyc(1);
      `CHK({in_reset_o, txd_o, tx_ready_o, tx_irq_o, rx_irq_o}, 5'b11000)
      `CHK({pia_port_sel_o, pia_ddr_sel_o}, 2'b01)
      t_pia(8'h04, 2'b10);
      t_pia(8'hfb, 2'b01);
      t_pia(8'hff, 2'b10);
      pia_data_acc_i = 1'b0;
      cyc(1);
      `CHK({pia_port_sel_o, pia_ddr_sel_o}, 2'b00)
      for (int f = 0; f < 8; f++)
         t_frame({3'h0, f[2:0], 2'h0}, {f[2:0], 5'h15});
      t_frame(8'h15, 8'h6b);
      t_frame(8'h0a, 8'h3d);
      t_irq();
      t_break();
      give_verdict();
   end
endmodule

`default_nettype wire
